// file: bench/hcc_chk.sv
// port assertions for the configuration bank
`timescale 1ns/1ns
`default_nettype none
module hcc_chk
	import hcc_pkg::*;
(
	// clock and reset
	input wire logic            ref_clk,
	input wire logic            nrst,
	// watched ports
	input wire hcc_pkg::hcc_rd_s rd,
	input wire logic [7:0]      rd_data,
	input wire logic            rd_valid,
	input wire logic            reg09_tmo_en,
	input wire logic            lp_entry_req,
	input wire logic            lp_entry_allow,
	input wire logic [7:0]      host_timeout,
	input wire logic [7:0]      applied_timeout,
	input wire logic [3:0]      port_power_req,
	input wire logic [3:0]      port_power_control_pins
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// reads of the two registers
	sequence s_rd_cfg; rd.valid && rd.addr == DEV_CFG_OFS; endsequence
	sequence s_rd_chg; rd.valid && rd.addr == CHG_SUP_OFS; endsequence
	chk_read_answer: assert property (rd.valid ##1 !rd.valid |-> rd_valid ##1 !rd_valid)
		else $error("read answer missing or too long");
	chk_data_idle: assert property (!rd.valid |=> rd_data == 8'h00)
		else $error("read data not cleared");
	chk_rsvd_one: assert property (s_rd_cfg |=> rd_data[RSVD_ONE_BIT])
		else $error("reserved bit 4 not one");
	chk_rsvd_zero: assert property (s_rd_cfg |=> !rd_data[RSVD_ZERO_BIT])
		else $error("reserved bit 0 not zero");
	chk_chg_upper: assert property (s_rd_chg |=> rd_data[7:4] == 4'h0)
		else $error("charge upper nibble not zero");
	chk_tmo_zero: assert property (host_timeout == TMO_ZERO |=> applied_timeout == TMO_ZERO)
		else $error("zero timeout altered");
	chk_tmo_gate: assert property (!reg09_tmo_en |=> applied_timeout == $past(host_timeout))
		else $error("timeout changed without enable");
	chk_lp_no_req: assert property (!lp_entry_req |=> !lp_entry_allow)
		else $error("low power allowed without request");
	chk_pwr_idle: assert property (port_power_req == 4'h0 |=> port_power_control_pins == 4'h0)
		else $error("port power without request");
endmodule : hcc_chk
bind hcc_regs hcc_chk hcc_chk_inst (.ref_clk, .nrst, .rd, .rd_data, .rd_valid, .reg09_tmo_en,
	.lp_entry_req, .lp_entry_allow, .host_timeout, .applied_timeout, .port_power_req, .port_power_control_pins);
`default_nettype wire

// file: bench/hcc_host.sv
// configuration master model: smbus host or eeprom byte loader
`timescale 1ns/1ns
`default_nettype none
module hcc_host (
	// clock
	input wire logic             ref_clk,
	// register access
	output var hcc_pkg::hcc_wr_s wr,
	output var hcc_pkg::hcc_rd_s rd,
	input wire logic [7:0]       rd_data,
	input wire logic             rd_valid
);
	import hcc_pkg::*;
	initial begin
		wr = '0;
		rd = '0;
	end
	// one byte write; idle bus shows inverted data so stale values never match
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		wr <= '{1'b1, a, d};
		@(negedge ref_clk);
		wr <= '{1'b0, ~a, ~d};
		@(negedge ref_clk);
	endtask : put
	// one byte read, answer taken while rd_valid stands
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		rd <= '{1'b1, a};
		@(negedge ref_clk);
		rd <= '{1'b0, ~a};
		d = rd_valid ? rd_data : 8'hXX;
		@(negedge ref_clk);
	endtask : get
endmodule : hcc_host
`default_nettype wire

// file: bench/hcc_regs_tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ns
`default_nettype none
module hcc_regs_tb;
	import hcc_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, reg09_tmo_en = 1'b0, force_accept_seen = 1'b0;
	logic upstream_disconnect = 1'b0, lp_entry_req = 1'b0, rd_valid, lp_entry_allow;
	logic string_write_unlock, serial_write_unlock;
	logic [7:0] rd_data, applied_timeout, host_timeout = 8'h05;
	logic [3:0] port_power_req = 4'h0, port_power_control_pins, charge_port_enable;
	hcc_mode_e mode = HCC_MODE_PIN;
	hcc_strap_s strap = '{1'b1, 1'b0, 4'hA};
	hcc_wr_s wr;
	hcc_rd_s rd;
	int n_errors = 0, cmp_count = 0;
	always #25 ref_clk = ~ref_clk;
	hcc_regs hcc_regs_inst (.ref_clk, .nrst, .mode, .wr, .rd, .rd_data, .rd_valid, .strap, .reg09_tmo_en,
		.force_accept_seen, .upstream_disconnect, .lp_entry_req, .lp_entry_allow, .host_timeout,
		.applied_timeout, .port_power_req, .port_power_control_pins, .charge_port_enable,
		.string_write_unlock, .serial_write_unlock);
	hcc_host hcc_host_inst (.ref_clk, .wr, .rd, .rd_data, .rd_valid);
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		hcc_host_inst.get(a, d);
		chk(d, exp);
	endtask : rdc
	task automatic summarize;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// watchdog, far beyond the 67 cycles the tests need
	initial begin
		#200000;
		n_errors++;
		summarize;
	end
	// inputs change only at falling edges
	initial begin
		cyc(5);
		nrst = 1'b1;
		cyc(2);
		rdc(DEV_CFG_OFS, 8'h18);
		rdc(CHG_SUP_OFS, 8'h0A);
		chk({4'h0, charge_port_enable}, 8'h0A);
		port_power_req = 4'h4;
		cyc(2);
		chk({4'h0, port_power_control_pins}, 8'h01);
		hcc_host_inst.put(DEV_CFG_OFS, 8'hFF);
		rdc(DEV_CFG_OFS, 8'h18);
		mode = HCC_MODE_I2C;
		hcc_host_inst.put(DEV_CFG_OFS, 8'hFF);
		rdc(DEV_CFG_OFS, 8'h3C);
		hcc_host_inst.put(CHG_SUP_OFS, 8'hFF);
		rdc(CHG_SUP_OFS, 8'h0F);
		hcc_host_inst.put(DEV_CFG_OFS, 8'h00);
		rdc(DEV_CFG_OFS, 8'h10);
		chk({4'h0, port_power_control_pins}, 8'h04);
		mode = HCC_MODE_SMB;
		hcc_host_inst.put(DEV_CFG_OFS, 8'hFF);
		rdc(DEV_CFG_OFS, 8'hFE);
		chk({6'h00, string_write_unlock, serial_write_unlock}, 8'h03);
		hcc_host_inst.put(CHG_SUP_OFS, 8'hF5);
		rdc(CHG_SUP_OFS, 8'h05);
		lp_entry_req = 1'b1;
		cyc(2);
		chk({7'h00, lp_entry_allow}, 8'h00);
		force_accept_seen = 1'b1;
		cyc(1);
		force_accept_seen = 1'b0;
		cyc(3);
		chk({7'h00, lp_entry_allow}, 8'h01);
		upstream_disconnect = 1'b1;
		cyc(1);
		upstream_disconnect = 1'b0;
		cyc(2);
		chk({7'h00, lp_entry_allow}, 8'h00);
		cyc(2);
		chk(applied_timeout, 8'h05);
		reg09_tmo_en = 1'b1;
		cyc(2);
		chk(applied_timeout, TMO_MAX);
		host_timeout = 8'h00;
		cyc(2);
		chk(applied_timeout, TMO_ZERO);
		rdc(8'h20, 8'h00);
		// forced state set just before a mid-run reset, other strap levels
		force_accept_seen = 1'b1;
		cyc(1);
		force_accept_seen = 1'b0;
		nrst = 1'b0;
		strap = '{1'b0, 1'b1, 4'h5};
		host_timeout = 8'h07;
		cyc(3);
		nrst = 1'b1;
		cyc(2);
		rdc(DEV_CFG_OFS, 8'h14);
		rdc(CHG_SUP_OFS, 8'h05);
		chk({4'h0, charge_port_enable}, 8'h05);
		chk({6'h00, string_write_unlock, serial_write_unlock}, 8'h00);
		chk({4'h0, port_power_control_pins}, 8'h04);
		chk(applied_timeout, 8'h07);
		chk({7'h00, lp_entry_allow}, 8'h01);
		hcc_host_inst.put(DEV_CFG_OFS, 8'h24);
		cyc(1);
		chk({7'h00, lp_entry_allow}, 8'h00);
		summarize;
	end
endmodule : hcc_regs_tb
`default_nettype wire

// file: hdl/hcc_pkg.sv
// package: offsets, fields, resets and carriers of the hub configuration bank
package hcc_pkg;
	localparam logic [7:0] DEV_CFG_OFS      = 8'h05;
	localparam logic [7:0] CHG_SUP_OFS      = 8'h06;
	localparam logic [7:0] REG09_OFS        = 8'h09;
	localparam int         STR_UNLOCK_BIT   = 7;
	localparam int         SER_UNLOCK_BIT   = 6;
	localparam int         LP_BLOCK_BIT     = 5;
	localparam int         RSVD_ONE_BIT     = 4;
	localparam int         GANGED_BIT       = 3;
	localparam int         PWR_RPT_BIT      = 2;
	localparam int         TMO_OVR_BIT      = 1;
	localparam int         RSVD_ZERO_BIT    = 0;
	localparam int         REG09_TMO_EN_BIT = 6;
	localparam logic [7:0] DEV_CFG_RST      = 8'h10;
	localparam logic [7:0] DEV_CFG_WMASK    = 8'hEE;
	localparam logic [7:0] DEV_CFG_EE_MASK  = 8'h2C;
	localparam logic [3:0] CHG_EN_RST       = 4'h0;
	localparam int         NUM_PORTS        = 4;
	localparam logic [7:0] TMO_MAX          = 8'hFF;
	localparam logic [7:0] TMO_ZERO         = 8'h00;

	// configuration source
	typedef enum logic [2:0] {
		HCC_MODE_PIN = 3'b001,
		HCC_MODE_I2C = 3'b010,
		HCC_MODE_SMB = 3'b100
	} hcc_mode_e;

	// one byte write into the bank
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} hcc_wr_s;

	// one byte read request
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
	} hcc_rd_s;

	// straps sampled at reset release
	typedef struct packed {
		logic       shared_power;
		logic       power_report;
		logic [3:0] charge_en;
	} hcc_strap_s;
endpackage : hcc_pkg

// file: hdl/hcc_regs.sv
// hub device configuration and charge-port support registers
//
// Function
// (RQ1) string-unlock bit, reset 0, gates writes to string/length/language registers
// (RQ2) serial-unlock bit, reset 0, gates writes to serial string and length
// (RQ3) block bit set stops U1/U2 initiate and accept unless force-accept seen
// (RQ4) after force-accept exchange allow U1/U2 until power-on reset or upstream disconnect
// (RQ5) bit 4 of device configuration reads as 1
// (RQ6) ganged bit captures shared-power strap at reset release
// (RQ7) report on: ganged drives all ports via port-1 output, else per port
// (RQ8) power-report bit loads from its strap at reset release
// (RQ9) EEPROM loads block, ganged, report bits; SMBus host may overwrite them
// (RQ10) override maps nonzero downstream timeout to FFh, zero stays zero
// (RQ11) timeout override applies only with bit 6 of register 09h set
// (RQ12) bit 0 of device configuration reads as 0
// (RQ13) upper nibble of charge support register reads as 0
// (RQ14) charge-enable bit n enables charging features on downstream port n+1
// (RQ15) charge-enable bits initialise from port power control pins at reset release
// (RQ16) EEPROM or SMBus may replace charge-enable bits
// (RQ17) writes to reserved or locked bits are ignored silently
`timescale 1ns/1ns
`default_nettype none
module hcc_regs (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// configuration source and register access
	input  wire hcc_pkg::hcc_mode_e mode,
	input  wire hcc_pkg::hcc_wr_s  wr,
	input  wire hcc_pkg::hcc_rd_s  rd,
	output var  logic [7:0]        rd_data,
	output var  logic              rd_valid,
	// strap pins
	input  wire hcc_pkg::hcc_strap_s strap,
	// register 09h bit 6 from the neighbouring bank
	input  wire logic              reg09_tmo_en,
	// link power management events
	input  wire logic              force_accept_seen,
	input  wire logic              upstream_disconnect,
	input  wire logic              lp_entry_req,
	output var  logic              lp_entry_allow,
	// downstream timeout from host software
	input  wire logic [7:0]        host_timeout,
	output var  logic [7:0]        applied_timeout,
	// port power and charging
	input  wire logic [3:0]        port_power_req,
	output var  logic [3:0]        port_power_control_pins,
	output var  logic [3:0]        charge_port_enable,
	// write enables to string and serial banks
	output var  logic              string_write_unlock,
	output var  logic              serial_write_unlock
);
	import hcc_pkg::*;

	logic [7:0] dev_cfg_r;
	logic [7:0] dev_cfg_nxt;
	logic [3:0] chg_en_r;
	logic [3:0] chg_en_nxt;
	logic       strap_done_r;
	logic       force_ok_r;
	logic       wr_dev;
	logic       wr_chg;
	logic [7:0] wmask;
	logic       lp_block;
	logic       tmo_ovr_on;
	logic       force_ok_nxt;
	logic       wr_allowed;
	logic       gang_on;
	logic       cfg_ganged;
	logic       cfg_report_off;
	logic       cfg_lp_block;
	logic       cfg_tmo_ovr;
	logic [7:0] dev_cfg_strap;
	logic [7:0] rd_mux;
	logic [7:0] tmo_mapped;
	wire  logic [NUM_PORTS-1:0] pwr_nxt;

	// address match used for both read and write decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// nonzero host timeout saturates to the maximum, zero keeps the timer off
	function automatic logic [7:0] tmo_map(input logic [7:0] t);
		tmo_map = (t == TMO_ZERO) ? TMO_ZERO : TMO_MAX;
	endfunction : tmo_map

	// eeprom may only touch the power bits; smbus reaches every writable bit
	always_comb begin
		wmask = 8'h00;
		unique case (mode)
			HCC_MODE_I2C: wmask = DEV_CFG_EE_MASK;     // RQ9
			HCC_MODE_SMB: wmask = DEV_CFG_WMASK;       // RQ9
			HCC_MODE_PIN: wmask = 8'h00;               // RQ17
			default:      wmask = 8'h00;
		endcase
	end

	// write strobes; pin mode has no writer at all
	always_comb begin
		wr_allowed = (mode != HCC_MODE_PIN);   // RQ17
		wr_dev     = wr.valid && hit(wr.addr, DEV_CFG_OFS) && wr_allowed;   // RQ9
		wr_chg     = wr.valid && hit(wr.addr, CHG_SUP_OFS) && wr_allowed;   // RQ16
	end

	// merge writes under mask, reserved bits forced to their fixed read values
	always_comb begin
		dev_cfg_nxt = dev_cfg_r;
		if (wr_dev) begin
			dev_cfg_nxt = (dev_cfg_r & ~wmask) | (wr.data & wmask);   // RQ17
		end
		dev_cfg_nxt[RSVD_ONE_BIT]  = 1'b1;   // RQ5
		dev_cfg_nxt[RSVD_ZERO_BIT] = 1'b0;   // RQ12
	end

	// charge byte: only the low nibble is stored, the reserved nibble is dropped
	always_comb begin
		chg_en_nxt = chg_en_r;
		if (wr_chg) begin
			chg_en_nxt = wr.data[3:0];   // RQ13 RQ16
		end
	end

	// reset pattern with the two strap levels dropped into their bit positions
	always_comb begin
		dev_cfg_strap              = DEV_CFG_RST;
		dev_cfg_strap[GANGED_BIT]  = strap.shared_power;   // RQ6
		dev_cfg_strap[PWR_RPT_BIT] = strap.power_report;   // RQ8
	end

	// capture strobe: low through reset and on the first clock after its release
	// a write landing in that clock is lost, the straps take priority
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			strap_done_r <= 1'b0;
		end else begin
			strap_done_r <= 1'b1;
		end
	end

	// straps wait one clock after release so the reset branch only loads constants
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			dev_cfg_r <= DEV_CFG_RST;   // RQ1 RQ2
		end else if (!strap_done_r) begin
			dev_cfg_r <= dev_cfg_strap;   // RQ6 RQ8
		end else begin
			dev_cfg_r <= dev_cfg_nxt;   // RQ9 RQ17
		end
	end

	// charge enables follow the charge-enable straps at release, then the writers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			chg_en_r <= CHG_EN_RST;
		end else if (!strap_done_r) begin
			chg_en_r <= strap.charge_en;   // RQ15
		end else begin
			chg_en_r <= chg_en_nxt;   // RQ16
		end
	end

	// force-accept next state; a set in the same cycle as a disconnect wins
	always_comb begin
		force_ok_nxt = force_ok_r;
		if (force_accept_seen) begin
			force_ok_nxt = 1'b1;   // RQ4
		end else if (upstream_disconnect) begin
			force_ok_nxt = 1'b0;   // RQ4
		end
	end

	// reset is the other way out of the forced state
	// holding it any longer would let a new host inherit the permission
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			force_ok_r <= 1'b0;   // RQ4
		end else begin
			force_ok_r <= force_ok_nxt;
		end
	end

	// named views of the stored fields keep the consumers readable
	always_comb begin
		cfg_ganged     = dev_cfg_r[GANGED_BIT];
		cfg_report_off = dev_cfg_r[PWR_RPT_BIT];
		cfg_lp_block   = dev_cfg_r[LP_BLOCK_BIT];
		cfg_tmo_ovr    = dev_cfg_r[TMO_OVR_BIT];
	end

	// ganging only applies while port status reporting is enabled
	always_comb begin
		gang_on = !cfg_report_off && cfg_ganged;   // RQ7
	end

	// read selection; unmapped offsets answer zero rather than an error
	always_comb begin
		rd_mux = 8'h00;
		if (hit(rd.addr, DEV_CFG_OFS)) begin
			rd_mux = dev_cfg_r;   // RQ5 RQ12
		end else if (hit(rd.addr, CHG_SUP_OFS)) begin
			rd_mux = {4'h0, chg_en_r};   // RQ13
		end
	end

	// read answer follows the request one clock later and stands as long as the request does
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd.valid;
		end
	end

	// data drops back to zero after the answer so stale bytes never look valid
	// costs a mux level on the data path, cheap at this clock rate
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rd_data <= 8'h00;
		end else if (rd.valid) begin
			rd_data <= rd_mux;
		end else begin
			rd_data <= 8'h00;
		end
	end

	// link power block, lifted once a force-accept has been exchanged
	always_comb begin
		lp_block = cfg_lp_block && !force_ok_r;   // RQ3 RQ4
	end

	// override needs both its own bit and the enable from the neighbouring bank
	always_comb begin
		tmo_ovr_on = cfg_tmo_ovr && reg09_tmo_en;   // RQ11
	end

	// link power gate, one clock behind the request
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lp_entry_allow <= 1'b0;
		end else begin
			lp_entry_allow <= lp_entry_req && !lp_block;   // RQ3
		end
	end

	// timeout seen by the downstream ports; passthrough unless both enables are set
	always_comb begin
		tmo_mapped = host_timeout;
		if (tmo_ovr_on) begin
			tmo_mapped = tmo_map(host_timeout);   // RQ10
		end
	end

	// registered so the link timers never see a decode glitch
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			applied_timeout <= TMO_ZERO;
		end else begin
			applied_timeout <= tmo_mapped;
		end
	end

	// per-port next value; ganged mode folds every request onto the port-1 output
	// with reporting off each port simply follows its own request
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			if (gi == 0) begin : g_first
				assign pwr_nxt[gi] = gang_on ? |port_power_req : port_power_req[gi];   // RQ7
			end else begin : g_rest
				assign pwr_nxt[gi] = gang_on ? 1'b0 : port_power_req[gi];   // RQ7
			end
		end
	endgenerate

	// one register for all port outputs avoids several processes sharing a vector
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			port_power_control_pins <= '0;
		end else begin
			port_power_control_pins <= pwr_nxt;
		end
	end

	// charge enables leave through a flop like every other output
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			charge_port_enable <= CHG_EN_RST;
		end else begin
			charge_port_enable <= chg_en_r;   // RQ14
		end
	end

	// unlock levels for the string and serial banks, which enforce the lock themselves
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			string_write_unlock <= 1'b0;
			serial_write_unlock <= 1'b0;
		end else begin
			string_write_unlock <= dev_cfg_r[STR_UNLOCK_BIT];   // RQ1
			serial_write_unlock <= dev_cfg_r[SER_UNLOCK_BIT];   // RQ2
		end
	end
endmodule : hcc_regs
`default_nettype wire
